// ---- rtl/pad_mux_map.svh ----
// constants for the pad function multiplexer
`ifndef PAD_MUX_MAP_SVH
`define PAD_MUX_MAP_SVH

// ----------------------------------------
// pad configuration field positions
// ----------------------------------------
`define PCFG_SEL_LSB 0
`define PCFG_SEL_MSB 1
`define PCFG_INBUF_BIT 2
`define PCFG_EDGE_BIT 3
`define PCFG_WIDTH 4

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PCFG_RESET 4'h0
`define SEL_PRIMARY 2'h0
`define SEL_ALT_ONE 2'h1
`define SEL_ALT_TWO 2'h2
`define SEL_ALT_THREE 2'h3
`define EDGE_SLOW 1'h0
`define EDGE_MEDIUM 1'h1

`endif

// ---- rtl/pad_mux_pkg.sv ----
// types for the pad function multiplexer
`default_nettype none

package pad_mux_pkg;

  typedef struct packed {
    logic edge_rate_ctrl;
    logic input_buffer_en;
    logic [1:0] alt_function_select;
  } pad_config_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } pad_func_t;

endpackage

`default_nettype wire

// ---- rtl/pad_input_select.sv ----
// per-peripheral pad selection for input functions
`default_nettype none

module pad_input_select #(
  parameter int NUM_PADS = 16,
  parameter int NUM_INPUTS = 4,
  parameter int SEL_W = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // pad inputs and choices
  input wire logic [NUM_PADS-1:0] pad_in_i,
  input wire logic [NUM_PADS-1:0] pad_inbuf_en_i,
  input wire logic [NUM_INPUTS*SEL_W-1:0] peripheral_pad_choice_i,
  // peripheral inputs
  output logic [NUM_INPUTS-1:0] periph_in_o
);

  logic [NUM_INPUTS-1:0] in_reg;
  logic [NUM_INPUTS-1:0] in_next;

  // ----------------------------------------
  // input source selection
  // ----------------------------------------
  always_comb begin
    logic [SEL_W-1:0] idx;
    idx = '0;
    for (int k = 0; k < NUM_INPUTS; k++) begin
      idx = peripheral_pad_choice_i[k*SEL_W +: SEL_W];
      in_next[k] = 1'b0;
      if (int'(idx) < NUM_PADS) begin
        in_next[k] = pad_in_i[idx] & pad_inbuf_en_i[idx];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      in_reg <= '0;
    end else begin
      in_reg <= in_next;
    end
  end

  assign periph_in_o = in_reg;

endmodule

`default_nettype wire

// ---- rtl/pad_function_multiplexer.sv ----
// pad function multiplexer top
`include "pad_mux_map.svh"
`default_nettype none

module pad_function_multiplexer #(
  parameter int NUM_PADS = 16,
  parameter int NUM_INPUTS = 4,
  parameter int SEL_W = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic [NUM_PADS-1:0] cfg_we_i,
  input wire pad_mux_pkg::pad_config_t [NUM_PADS-1:0] pad_config_wdata_i,
  input wire logic [NUM_INPUTS*SEL_W-1:0] input_source_select_reg_i,
  output pad_mux_pkg::pad_config_t [NUM_PADS-1:0] pad_config_reg_o,
  // peripheral side
  input wire pad_mux_pkg::pad_func_t [NUM_PADS-1:0] periph_func_i,
  output logic [NUM_PADS-1:0] periph_pad_in_o,
  output logic [NUM_INPUTS-1:0] periph_sel_in_o,
  // pads
  input wire logic [NUM_PADS-1:0] pad_in_i,
  output logic [NUM_PADS-1:0] pad_out_o,
  output logic [NUM_PADS-1:0] pad_oe_n_o,
  output logic [NUM_PADS-1:0] pad_edge_rate_o
);

  // ----------------------------------------
  // state and next values
  // ----------------------------------------
  pad_mux_pkg::pad_config_t [NUM_PADS-1:0] cfg_reg;
  pad_mux_pkg::pad_config_t [NUM_PADS-1:0] cfg_next;

  logic [NUM_PADS-1:0] sync1_reg;
  logic [NUM_PADS-1:0] sync1_next;
  logic [NUM_PADS-1:0] sync2_reg;
  logic [NUM_PADS-1:0] sync2_next;

  logic [NUM_PADS-1:0] out_reg;
  logic [NUM_PADS-1:0] out_next;
  logic [NUM_PADS-1:0] oe_n_reg;
  logic [NUM_PADS-1:0] oe_n_next;

  logic [NUM_PADS-1:0] edge_reg;
  logic [NUM_PADS-1:0] edge_next;

  logic [NUM_PADS-1:0] pin_reg;
  logic [NUM_PADS-1:0] pin_next;
  logic [NUM_PADS-1:0] inbuf_vec;

  // ----------------------------------------
  // function decoding
  // ----------------------------------------
  function automatic logic pick_function(
    input logic [3:0] vec,
    input logic [1:0] sel
  );
    logic bit_sel;
    bit_sel = 1'b0;
    case (sel)
      `SEL_PRIMARY: begin
        bit_sel = vec[0];
      end
      `SEL_ALT_ONE: begin
        bit_sel = vec[1];
      end
      `SEL_ALT_TWO: begin
        bit_sel = vec[2];
      end
      `SEL_ALT_THREE: begin
        bit_sel = vec[3];
      end
      default: begin
        bit_sel = 1'b0;
      end
    endcase
    return bit_sel;
  endfunction

  function automatic logic pad_enable_n(
    input logic [3:0] oe,
    input logic [1:0] sel
  );
    return ~pick_function(oe, sel);
  endfunction

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    for (int p = 0; p < NUM_PADS; p++) begin
      if (cfg_we_i[p]) begin
        cfg_next[p] = pad_config_wdata_i[p];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cfg_reg <= {NUM_PADS{`PCFG_RESET}};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------
  // pad input synchroniser
  // ----------------------------------------
  always_comb begin
    sync1_next = pad_in_i;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ----------------------------------------
  // output function steering
  // ----------------------------------------
  always_comb begin
    out_next = '0;
    oe_n_next = '1;
    for (int p = 0; p < NUM_PADS; p++) begin
      out_next[p] = pick_function(periph_func_i[p].dout,
        cfg_reg[p].alt_function_select);
      oe_n_next[p] = pad_enable_n(periph_func_i[p].oe,
        cfg_reg[p].alt_function_select);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      out_reg <= '0;
      oe_n_reg <= '1;
    end else begin
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ----------------------------------------
  // edge rate control
  // ----------------------------------------
  always_comb begin
    edge_next = '0;
    for (int p = 0; p < NUM_PADS; p++) begin
      edge_next[p] = cfg_reg[p].edge_rate_ctrl;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      edge_reg <= {NUM_PADS{`EDGE_SLOW}};
    end else begin
      edge_reg <= edge_next;
    end
  end

  // ----------------------------------------
  // input buffer gating
  // ----------------------------------------
  always_comb begin
    inbuf_vec = '0;
    pin_next = '0;
    for (int p = 0; p < NUM_PADS; p++) begin
      inbuf_vec[p] = cfg_reg[p].input_buffer_en;
      pin_next[p] = sync2_reg[p] & inbuf_vec[p];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------
  // shared input selection
  // ----------------------------------------
  pad_input_select #(
    .NUM_PADS(NUM_PADS),
    .NUM_INPUTS(NUM_INPUTS),
    .SEL_W(SEL_W)
  ) u_in_sel (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pad_in_i(sync2_reg),
    .pad_inbuf_en_i(inbuf_vec),
    .peripheral_pad_choice_i(input_source_select_reg_i),
    .periph_in_o(periph_sel_in_o)
  );

  // ----------------------------------------
  // output ports
  // ----------------------------------------
  assign pad_config_reg_o = cfg_reg;
  assign pad_out_o = out_reg;
  assign pad_oe_n_o = oe_n_reg;
  assign pad_edge_rate_o = edge_reg;
  assign periph_pad_in_o = pin_reg;

endmodule

`default_nettype wire

// ---- bench/pad_mux_monitor.sv ----
// assertions for the pad function multiplexer
`default_nettype none

module pad_mux_monitor #(
  parameter int NUM_PADS = 16,
  parameter int NUM_INPUTS = 4,
  parameter int SEL_W = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // watched ports
  input wire logic [NUM_INPUTS*SEL_W-1:0] input_source_select_reg_i,
  input wire pad_mux_pkg::pad_config_t [NUM_PADS-1:0] pad_config_reg_o,
  input wire pad_mux_pkg::pad_func_t [NUM_PADS-1:0] periph_func_i,
  input wire logic [NUM_PADS-1:0] periph_pad_in_o,
  input wire logic [NUM_INPUTS-1:0] periph_sel_in_o,
  input wire logic [NUM_PADS-1:0] pad_out_o,
  input wire logic [NUM_PADS-1:0] pad_oe_n_o,
  input wire logic [NUM_PADS-1:0] pad_edge_rate_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // checks on pad zero, peripheral input zero and the reset state of all pads
  // ----
  wire logic d0 = periph_func_i[0].dout[pad_config_reg_o[0].alt_function_select];
  wire logic e0 = periph_func_i[0].oe[pad_config_reg_o[0].alt_function_select];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence inbuf_off;
    !pad_config_reg_o[0].input_buffer_en [*4];
  endsequence
  reset_state_a: assert property ($rose(reset_n_i) |->
    pad_config_reg_o == '0 && &pad_oe_n_o) else $error("bad reset state");
  out_select_a: assert property ($past(reset_n_i) |-> pad_out_o[0] == $past(d0))
    else $error("pad output not selected function");
  in_gate_a: assert property (inbuf_off |-> !periph_pad_in_o[0])
    else $error("pad input passed with buffer off");
  in_route_a: assert property ($past(reset_n_i) |-> periph_sel_in_o[0] ==
    periph_pad_in_o[$past(input_source_select_reg_i[SEL_W-1:0])]) else $error("bad source");
  edge_rate_a: assert property ($past(reset_n_i) |->
    pad_edge_rate_o[0] == $past(pad_config_reg_o[0].edge_rate_ctrl)) else $error("edge rate");
  oe_dir_a: assert property ($past(reset_n_i) |-> pad_oe_n_o[0] == !$past(e0))
    else $error("output enable wrong");
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the pad function multiplexer
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // stimulus and checks
  // ----
  logic clk_sys_i = 0, reset_n_i = 0;
  logic [1:0] cfg_we_i = '0, pad_in_i = '0, input_source_select_reg_i = '0;
  pad_mux_pkg::pad_config_t [1:0] pad_config_wdata_i = '0, pad_config_reg_o;
  pad_mux_pkg::pad_func_t [1:0] periph_func_i = {2{8'ha6}};
  logic [1:0] periph_pad_in_o, periph_sel_in_o, pad_out_o, pad_oe_n_o, pad_edge_rate_o;
  int num_errors = 0, total_checks = 0;
  // cfg, out, oe_n, edge
  logic [6:0] rows [4] = '{7'h02, 7'h4d, 7'h10, 7'h5f};
  pad_function_multiplexer #(.NUM_PADS(2), .NUM_INPUTS(2), .SEL_W(1)) uut (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .cfg_we_i(cfg_we_i),
    .pad_config_wdata_i(pad_config_wdata_i),
    .input_source_select_reg_i(input_source_select_reg_i),
    .pad_config_reg_o(pad_config_reg_o),
    .periph_func_i(periph_func_i),
    .periph_pad_in_o(periph_pad_in_o),
    .periph_sel_in_o(periph_sel_in_o),
    .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o),
    .pad_edge_rate_o(pad_edge_rate_o)
  );
  task chk(string n, logic [3:0] e, logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task wr(int p, logic [3:0] c);
    cfg_we_i[p] <= 1'b1;
    pad_config_wdata_i[p] <= c;
    cyc(1);
    cfg_we_i[p] <= 1'b0;
  endtask
  task test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial forever #20 clk_sys_i = ~clk_sys_i;
  initial begin
    cyc(5);
    reset_n_i <= 1'b1;
    cyc(1);
    chk("cfg", 4'h0, pad_config_reg_o[0]);
    chk("oe_n", 4'h3, 4'(pad_oe_n_o));
    $display("reset test done");
    foreach (rows[i]) begin
      wr(0, rows[i][6:3]);
      cyc(3);
      chk("cfg", rows[i][6:3], pad_config_reg_o[0]);
      chk("out", 4'(rows[i][2]), 4'(pad_out_o[0]));
      chk("oe_n", 4'(rows[i][1]), 4'(pad_oe_n_o[0]));
      chk("edge", 4'(rows[i][0]), 4'(pad_edge_rate_o[0]));
      $display("row %0d done", i);
    end
    pad_in_i <= 2'h3;
    input_source_select_reg_i <= 2'h1;
    cyc(5);
    chk("pad_in", 4'h0, 4'(periph_pad_in_o));
    wr(1, 4'h4);
    cyc(5);
    chk("pad_in", 4'h2, 4'(periph_pad_in_o));
    chk("sel_in", 4'h1, 4'(periph_sel_in_o));
    chk("out", 4'h1, 4'(pad_out_o));
    chk("oe_n", 4'h3, 4'(pad_oe_n_o));
    chk("edge", 4'h1, 4'(pad_edge_rate_o));
    $display("input test done");
    reset_n_i <= 1'b0;
    cyc(2);
    reset_n_i <= 1'b1;
    cyc(1);
    chk("cfg", 4'h0, pad_config_reg_o[1]);
    chk("oe_n", 4'h3, 4'(pad_oe_n_o));
    chk("out", 4'h0, 4'(pad_out_o));
    $display("second reset test done");
    test_done();
  end
endmodule

bind pad_function_multiplexer pad_mux_monitor #(.NUM_PADS(NUM_PADS),
  .NUM_INPUTS(NUM_INPUTS), .SEL_W(SEL_W)) mon (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .input_source_select_reg_i(input_source_select_reg_i),
  .pad_config_reg_o(pad_config_reg_o),
  .periph_func_i(periph_func_i),
  .periph_pad_in_o(periph_pad_in_o),
  .periph_sel_in_o(periph_sel_in_o),
  .pad_out_o(pad_out_o),
  .pad_oe_n_o(pad_oe_n_o),
  .pad_edge_rate_o(pad_edge_rate_o)
);

`default_nettype wire
